// ===== rtl/cfg_regs_pkg.sv
/*
 * constants, register map and carrier types for the converter configuration bank.
 * assumes a single synchronous clock domain shared with the serial control port decoder.
 */
package cfg_regs_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;
    localparam int          SAMPLE_W        = 12;
    localparam int          NUM_CH          = 4;
    // register offsets
    localparam logic [7:0]  ADDR_INDEX      = 8'h05;
    localparam logic [7:0]  ADDR_MODES      = 8'h08;
    localparam logic [7:0]  ADDR_CLOCK      = 8'h09;
    localparam logic [7:0]  ADDR_TEST       = 8'h0D;
    localparam logic [7:0]  ADDR_OUTFMT     = 8'h14;
    localparam logic [7:0]  ADDR_COMMIT     = 8'hFF;
    // reset values
    localparam logic [7:0]  RST_INDEX       = 8'h0F;
    localparam logic [7:0]  RST_MODES       = 8'h00;
    localparam logic [7:0]  RST_CLOCK       = 8'h01;
    localparam logic [7:0]  RST_TEST        = 8'h00;
    localparam logic [7:0]  RST_OUTFMT      = 8'h00;
    localparam logic [7:0]  RST_COMMIT      = 8'h00;
    // writable bit masks, reserved bits stay zero
    localparam logic [7:0]  MASK_INDEX      = 8'h3F;
    localparam logic [7:0]  MASK_MODES      = 8'h07;
    localparam logic [7:0]  MASK_CLOCK      = 8'h01;
    localparam logic [7:0]  MASK_TEST       = 8'h3F;
    localparam logic [7:0]  MASK_OUTFMT     = 8'h47;
    // field positions
    localparam int          IDX_DCO_BIT     = 5;
    localparam int          IDX_FCO_BIT     = 4;
    localparam int          TST_LONG_HOLD   = 5;
    localparam int          TST_SHORT_HOLD  = 4;
    localparam int          FMT_LOWSWING    = 6;
    localparam int          FMT_INVERT      = 2;
    localparam int          COMMIT_BIT      = 0;
    localparam int          DCS_BIT         = 0;
    // pseudorandom generator shapes
    localparam int          LONG_STAGES     = 23;
    localparam int          LONG_TAP        = 18;
    localparam int          SHORT_STAGES    = 9;
    localparam int          SHORT_TAP       = 5;
    // sample patterns
    localparam logic [11:0] PAT_MID         = 12'h800;
    localparam logic [11:0] PAT_POSFS       = 12'hFFF;
    localparam logic [11:0] PAT_NEGFS       = 12'h000;
    localparam logic [11:0] PAT_CHECK_A     = 12'hAAA;
    localparam logic [11:0] PAT_CHECK_B     = 12'h555;
    localparam logic [11:0] PAT_SYNC        = 12'h03F;
    localparam logic [11:0] PAT_ONEHIGH     = 12'h800;
    localparam logic [11:0] PAT_MIXED_A     = 12'hA33;
    localparam logic [11:0] PAT_MIXED_B     = 12'h000;
    localparam logic [11:0] SIGN_FLIP       = 12'h800;
    localparam logic [1:0]  FMT_OFFSET_BIN  = 2'h0;
    localparam logic [1:0]  FMT_TWOS        = 2'h1;
    localparam logic [2:0]  MODE_RUN        = 3'h0;

    typedef enum logic [3:0] {
        TEST_OFF      = 4'h0,
        TEST_MID      = 4'h1,
        TEST_POSFS    = 4'h2,
        TEST_NEGFS    = 4'h3,
        TEST_CHECKER  = 4'h4,
        TEST_PN_LONG  = 4'h5,
        TEST_PN_SHORT = 4'h6,
        TEST_WORD_TGL = 4'h7,
        TEST_USER     = 4'h8,
        TEST_BIT_TGL  = 4'h9,
        TEST_SYNC     = 4'hA,
        TEST_ONE_HIGH = 4'hB,
        TEST_MIXED    = 4'hC
    } test_mode_type;

    // one register write from the serial port decoder
    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } reg_write_type;

    // active settings of one data channel
    typedef struct packed {
        logic [2:0] modes;
        logic       dcs_on;
        logic [5:0] test;
        logic [6:0] outfmt;
    } chan_cfg_type;
endpackage

// ===== rtl/adc_channel_config_regs.sv
/*
 * staged/active configuration bank with index-steered writes, commit strobe and
 * per-channel test pattern generation toward the serial outputs.
 * assumes the serial port decoder sits on clk_sys_in and presents one write per pulse;
 * conversion samples arrive on the same clock.
 */
`timescale 1ns/1ps
// Function
// - index bits 3:0 enable channels A..D as write targets, reset 0x0F.
// - index bit 5 picks data clock lane, bit 4 frame clock lane; reset off.
// - writes only land in units whose index bits are set; host sets index first.
// - commit bit at FF copies staged values into active registers; resets 0x00.
// - clock register bit 0 enables duty stabilizer, reset 0x01.
// - test codes 0 off, 1 midscale, 2 +full, 3 -full, 4 checkerboard.
// - code 5 long 23-stage sequence, code 6 short 9-stage sequence.
// - codes 7..C word toggle, user, bit toggle, sync, one-high, mixed frequency.
// - test codes 1..C replace conversion results with test data; codes D..F pass samples.
// - test bits 5 and 4 hold long and short generators in reset.
// - mixed frequency pattern follows the current output format.
// - output bit 6 picks standard (0) or reduced-swing (1) signalling.
// - output bit 2 inverts output data.
// - output bits 1:0: 00 offset binary, 01 twos complement.
module adc_channel_config_regs
    import cfg_regs_pkg::*;
#(
    parameter int CHANNELS = cfg_regs_pkg::NUM_CH
)
(
    input  wire logic                                     clk_sys_in,
    input  wire logic                                     rst_in,
    input  wire cfg_regs_pkg::reg_write_type              reg_write_in,
    input  wire logic [cfg_regs_pkg::ADDR_W-1:0]          rd_addr_in,
    input  wire logic [CHANNELS*cfg_regs_pkg::SAMPLE_W-1:0] sample_in,
    input  wire logic [15:0]                              user_pattern_in,
    output logic [cfg_regs_pkg::DATA_W-1:0]               rd_data_out,
    output logic [CHANNELS*cfg_regs_pkg::SAMPLE_W-1:0]    data_out,
    output logic [CHANNELS-1:0]                           dcs_enable_out,
    output logic [CHANNELS-1:0]                           low_swing_out,
    output logic [CHANNELS*3-1:0]                         run_mode_out,
    output logic [1:0]                                    clock_lane_low_swing_out,
    output logic [1:0]                                    clock_lane_invert_out
);
    import cfg_regs_pkg::*;

    // index register and per-unit staged/active copies; units 0..3 data, 4 frame, 5 data clock
    localparam int UNITS = CHANNELS + 2;
    logic [7:0]         index_q;
    logic [7:0]         commit_q;
    chan_cfg_type       staged_q [UNITS];
    chan_cfg_type       active_q [UNITS];
    logic [LONG_STAGES-1:0]  long_q  [CHANNELS];
    logic [SHORT_STAGES-1:0] short_q [CHANNELS];
    logic               toggle_q;

    // write decode
    wire wr_index  = reg_write_in.wr && (reg_write_in.addr == ADDR_INDEX);
    wire wr_commit = reg_write_in.wr && (reg_write_in.addr == ADDR_COMMIT);
    wire wr_modes  = reg_write_in.wr && (reg_write_in.addr == ADDR_MODES);
    wire wr_clock  = reg_write_in.wr && (reg_write_in.addr == ADDR_CLOCK);
    wire wr_test   = reg_write_in.wr && (reg_write_in.addr == ADDR_TEST);
    wire wr_outfmt = reg_write_in.wr && (reg_write_in.addr == ADDR_OUTFMT);
    wire do_commit = wr_commit && reg_write_in.data[COMMIT_BIT];
    wire [UNITS-1:0] unit_sel = {index_q[IDX_DCO_BIT], index_q[IDX_FCO_BIT],
                                 index_q[CHANNELS-1:0]};

    // index and commit registers; commit bit is never stored and always reads back zero
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            index_q  <= RST_INDEX;
            commit_q <= RST_COMMIT;
        end
        else
        begin
            if (wr_index)
                index_q <= reg_write_in.data & MASK_INDEX;
            commit_q <= RST_COMMIT;
        end
    end

    // staged and active copies per unit
    genvar u;
    generate
        for (u = 0; u < UNITS; u++)
        begin : g_unit
            chan_cfg_type staged_d;
            always_comb
            begin
                staged_d = staged_q[u];
                if (unit_sel[u])
                begin
                    if (wr_modes)
                        staged_d.modes = reg_write_in.data[2:0] & MASK_MODES[2:0];
                    if (wr_clock)
                        staged_d.dcs_on = reg_write_in.data[DCS_BIT];
                    if (wr_test)
                        staged_d.test = reg_write_in.data[5:0] & MASK_TEST[5:0];
                    if (wr_outfmt)
                        staged_d.outfmt = reg_write_in.data[6:0] & MASK_OUTFMT[6:0];
                end
            end
            always_ff @(posedge clk_sys_in)
            begin
                if (rst_in)
                begin
                    staged_q[u] <= '{modes: MODE_RUN, dcs_on: RST_CLOCK[DCS_BIT],
                                     test: RST_TEST[5:0], outfmt: RST_OUTFMT[6:0]};
                    active_q[u] <= '{modes: MODE_RUN, dcs_on: RST_CLOCK[DCS_BIT],
                                     test: RST_TEST[5:0], outfmt: RST_OUTFMT[6:0]};
                end
                else
                begin
                    staged_q[u] <= staged_d;
                    if (do_commit)
                        active_q[u] <= staged_d;
                end
            end
        end
    endgenerate

    // checkerboard/word toggle/user/mixed pattern phase
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            toggle_q <= 1'b0;
        else
            toggle_q <= ~toggle_q;
    end

    // per-channel generators and output mux
    genvar c;
    generate
        for (c = 0; c < CHANNELS; c++)
        begin : g_chan
            chan_cfg_type   cfg;
            test_mode_type  tmode;
            logic [11:0]    pat;
            logic [11:0]    fmt_word;
            logic [11:0]    out_d;
            logic [11:0]    samp;
            logic [11:0]    out_q;
            assign cfg   = active_q[c];
            assign tmode = test_mode_type'(cfg.test[3:0]);
            assign samp  = sample_in[c*SAMPLE_W +: SAMPLE_W];

            // generators restart from all ones while held
            always_ff @(posedge clk_sys_in)
            begin
                if (rst_in || cfg.test[TST_LONG_HOLD])
                    long_q[c] <= '1;
                else
                    long_q[c] <= {long_q[c][LONG_STAGES-2:0],
                                  long_q[c][LONG_STAGES-1] ^ long_q[c][LONG_TAP-1]};
                if (rst_in || cfg.test[TST_SHORT_HOLD])
                    short_q[c] <= '1;
                else
                    short_q[c] <= {short_q[c][SHORT_STAGES-2:0],
                                   short_q[c][SHORT_STAGES-1] ^ short_q[c][SHORT_TAP-1]};
            end

            // pattern select
            always_comb
            begin
                unique case (tmode)
                    TEST_OFF:      pat = samp;
                    TEST_MID:      pat = PAT_MID;
                    TEST_POSFS:    pat = PAT_POSFS;
                    TEST_NEGFS:    pat = PAT_NEGFS;
                    TEST_CHECKER:  pat = toggle_q ? PAT_CHECK_B : PAT_CHECK_A;
                    TEST_PN_LONG:  pat = long_q[c][SAMPLE_W-1:0];
                    TEST_PN_SHORT: pat = {short_q[c], short_q[c][SAMPLE_W-SHORT_STAGES-1:0]};
                    TEST_WORD_TGL: pat = toggle_q ? PAT_POSFS : PAT_NEGFS;
                    TEST_USER:     pat = toggle_q ? user_pattern_in[15:4] : user_pattern_in[11:0];
                    TEST_BIT_TGL:  pat = PAT_CHECK_A;
                    TEST_SYNC:     pat = PAT_SYNC;
                    TEST_ONE_HIGH: pat = PAT_ONEHIGH;
                    TEST_MIXED:    pat = toggle_q ? PAT_MIXED_B : PAT_MIXED_A;
                    default:       pat = samp;
                endcase
            end

            // twos complement applies to code 0 samples and the mixed pattern only; inversion applies to every word
            wire use_fmt = (tmode == TEST_OFF) || (tmode == TEST_MIXED);
            wire twos    = (cfg.outfmt[1:0] == FMT_TWOS);
            assign fmt_word = (use_fmt && twos) ? (pat ^ SIGN_FLIP) : pat;
            assign out_d    = cfg.outfmt[FMT_INVERT] ? ~fmt_word : fmt_word;

            always_ff @(posedge clk_sys_in)
            begin
                if (rst_in)
                    out_q <= PAT_NEGFS;
                else
                    out_q <= out_d;
            end

            assign data_out[c*SAMPLE_W +: SAMPLE_W] = out_q;
            assign dcs_enable_out[c] = cfg.dcs_on;
            assign low_swing_out[c]  = cfg.outfmt[FMT_LOWSWING];
            assign run_mode_out[c*3 +: 3] = cfg.modes;
        end
    endgenerate

    // clock lane settings, index 0 frame clock, 1 data clock
    assign clock_lane_low_swing_out = {active_q[CHANNELS+1].outfmt[FMT_LOWSWING],
                                       active_q[CHANNELS].outfmt[FMT_LOWSWING]};
    assign clock_lane_invert_out    = {active_q[CHANNELS+1].outfmt[FMT_INVERT],
                                       active_q[CHANNELS].outfmt[FMT_INVERT]};

    // readback shows the lowest selected data channel's staged copy
    logic [2:0] rd_unit;
    always_comb
    begin
        rd_unit = 3'h0;
        for (int i = CHANNELS - 1; i >= 0; i--)
            if (index_q[i])
                rd_unit = 3'(i);
    end
    wire chan_cfg_type rd_cfg = staged_q[rd_unit];
    always_comb
    begin
        unique case (rd_addr_in)
            ADDR_INDEX:  rd_data_out = index_q;
            ADDR_MODES:  rd_data_out = {5'h00, rd_cfg.modes};
            ADDR_CLOCK:  rd_data_out = {7'h00, rd_cfg.dcs_on};
            ADDR_TEST:   rd_data_out = {2'h0, rd_cfg.test};
            ADDR_OUTFMT: rd_data_out = {1'b0, rd_cfg.outfmt};
            ADDR_COMMIT: rd_data_out = commit_q;
            default:     rd_data_out = 8'h00;
        endcase
    end
endmodule

// ===== tb/adc_channel_config_regs_asserts.sv
/* port assertions for the configuration bank.
   assumes it is bound to the bank top, one clock, synchronous reset. */
`timescale 1ns/1ps
module adc_channel_config_regs_asserts
    import cfg_regs_pkg::*;
#(
    parameter int CHANNELS = 4
)
(
    input wire logic                                       clk_sys_in,
    input wire logic                                       rst_in,
    input wire cfg_regs_pkg::reg_write_type                reg_write_in,
    input wire logic [cfg_regs_pkg::ADDR_W-1:0]            rd_addr_in,
    input wire logic [CHANNELS*cfg_regs_pkg::SAMPLE_W-1:0] sample_in,
    input wire logic [15:0]                                user_pattern_in,
    input wire logic [cfg_regs_pkg::DATA_W-1:0]            rd_data_out,
    input wire logic [CHANNELS*cfg_regs_pkg::SAMPLE_W-1:0] data_out,
    input wire logic [CHANNELS-1:0]                        dcs_enable_out,
    input wire logic [CHANNELS-1:0]                        low_swing_out,
    input wire logic [CHANNELS*3-1:0]                      run_mode_out,
    input wire logic [1:0]                                 clock_lane_low_swing_out,
    input wire logic [1:0]                                 clock_lane_invert_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    // commit strobe and mapped read decode
    wire logic commit_w = reg_write_in.wr && reg_write_in.addr == ADDR_COMMIT && reg_write_in.data[COMMIT_BIT];
    wire logic mapped = rd_addr_in inside {ADDR_INDEX, ADDR_MODES, ADDR_CLOCK, ADDR_TEST, ADDR_OUTFMT, ADDR_COMMIT};

    AST_RESET_OUTS: assert property ($past(rst_in) |-> dcs_enable_out == '1 && low_swing_out == '0
        && run_mode_out == '0 && data_out == '0) else $error("outputs not at reset defaults");
    AST_INDEX_RESET: assert property ($past(rst_in) && rd_addr_in == ADDR_INDEX |-> rd_data_out == RST_INDEX)
        else $error("index register reset value wrong");
    AST_INDEX_WRITE: assert property (reg_write_in.wr && reg_write_in.addr == ADDR_INDEX ##1 rd_addr_in == ADDR_INDEX
        |-> rd_data_out == ($past(reg_write_in.data) & MASK_INDEX)) else $error("index write not read back");
    AST_COMMIT_ZERO: assert property (rd_addr_in == ADDR_COMMIT |-> rd_data_out == 8'h00)
        else $error("commit register not self clearing");
    AST_HOLD_NO_COMMIT: assert property (!$past(commit_w) && !$past(commit_w, 2) && !$past(commit_w, 3)
        && !$past(rst_in) && !$past(rst_in, 2) |-> $stable({dcs_enable_out, low_swing_out, run_mode_out,
        clock_lane_low_swing_out, clock_lane_invert_out})) else $error("active setting moved without commit");
    AST_CLOCK_RSVD: assert property (rd_addr_in == ADDR_CLOCK |-> (rd_data_out & ~MASK_CLOCK) == 8'h00)
        else $error("clock register reserved bits set");
    AST_FORMAT_RSVD: assert property (rd_addr_in == ADDR_OUTFMT |-> (rd_data_out & ~MASK_OUTFMT) == 8'h00)
        else $error("format register reserved bits set");
    AST_MODES_RSVD: assert property (rd_addr_in == ADDR_MODES |-> rd_data_out[7:3] == 5'h00)
        else $error("modes register reserved bits set");
    AST_UNMAPPED: assert property (!mapped |-> rd_data_out == 8'h00)
        else $error("unmapped address reads nonzero");
    // main scenarios reached
    cover property (commit_w);
    cover property (reg_write_in.wr && reg_write_in.addr == ADDR_INDEX);
    cover property (rd_addr_in == ADDR_TEST && rd_data_out != 8'h00);
endmodule

// ===== tb/host_ctl.sv
/* host controller model driving register writes and readback.
   assumes the bank takes a write on the rising edge with the strobe high. */
`timescale 1ns/1ps
module host_ctl
    import cfg_regs_pkg::*;
(
    input  wire logic                         clk_sys_in,
    input  wire logic [cfg_regs_pkg::DATA_W-1:0] rd_data_in,
    output cfg_regs_pkg::reg_write_type       reg_write_out,
    output logic [cfg_regs_pkg::ADDR_W-1:0]   rd_addr_out
);
    initial reg_write_out = '0;
    initial rd_addr_out = ADDR_INDEX; // index readback stands across reset release
    // one write pulse, strobe dropped a cycle later
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        reg_write_out <= '{1'b1, a, d};
        @(posedge clk_sys_in);
        reg_write_out.wr <= 1'b0;
    endtask
    // copy staged values into the active set
    task automatic commit;
        wr(ADDR_COMMIT, 8'h01);
    endtask
    // readback is combinational, sampled mid-cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_in);
        rd_addr_out <= a;
        @(negedge clk_sys_in);
        d = rd_data_in;
    endtask
endmodule

// ===== tb/adc_channel_config_regs_bench.sv
/* self-checking bench for the configuration bank.
   assumes package, bank, checker and host model are compiled first. */
`timescale 1ns/1ps
module adc_channel_config_regs_bench;
    import cfg_regs_pkg::*;
    localparam int CHANNELS = NUM_CH;
    logic          clk_sys_in = 1'b0;
    logic          rst_in = 1'b1;
    reg_write_type reg_write;
    logic [7:0]    rd_addr, rd_data, v;
    logic [47:0]   sample = 48'h123456789ABC;
    logic [47:0]   data_out;
    logic [3:0]    dcs, low_swing;
    logic [11:0]   run_mode, w;
    logic [1:0]    lane_ls, lane_inv;
    logic [11:0]   lvl [3] = '{PAT_MID, PAT_POSFS, PAT_NEGFS};
    int            fail_count = 0;
    int            check_count = 0;
    always #20 clk_sys_in = ~clk_sys_in;

    adc_channel_config_regs #(.CHANNELS(CHANNELS)) dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .reg_write_in(reg_write), .rd_addr_in(rd_addr), .sample_in(sample), .user_pattern_in(16'h1234),
        .rd_data_out(rd_data), .data_out(data_out), .dcs_enable_out(dcs), .low_swing_out(low_swing),
        .run_mode_out(run_mode), .clock_lane_low_swing_out(lane_ls), .clock_lane_invert_out(lane_inv));
    host_ctl host (.clk_sys_in(clk_sys_in), .rd_data_in(rd_data), .reg_write_out(reg_write), .rd_addr_out(rd_addr));

    // compare and count
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, v);
        chk(v, exp);
    endtask
    // commit a test code on channel B, compare two consecutive output words in either phase
    task automatic pchk(input logic [7:0] code, input logic [11:0] a, input logic [11:0] b);
        host.wr(ADDR_TEST, code);
        host.commit;
        settle;
        w = data_out[23:12];
        @(negedge clk_sys_in);
        chk({w, data_out[23:12]}, (w === a) ? {a, b} : {b, a});
    endtask
    // let commit reach the outputs
    task automatic settle;
        repeat (4) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
    endtask
    task automatic final_report;
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // hang guard
    initial
    begin
        repeat (20000) @(posedge clk_sys_in);
        fail_count++;
        final_report;
    end

    initial
    begin
        repeat (5) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        rchk(8'h06, 8'h00);
        rchk(ADDR_MODES, RST_MODES);
        rchk(ADDR_CLOCK, RST_CLOCK);
        rchk(ADDR_TEST, RST_TEST);
        rchk(ADDR_OUTFMT, RST_OUTFMT);
        rchk(ADDR_COMMIT, RST_COMMIT);
        rchk(ADDR_INDEX, RST_INDEX);
        chk(data_out, sample);
        host.wr(ADDR_INDEX, 8'h3F);
        rchk(ADDR_INDEX, 8'h3F);
        // channel A only; staged clock change waits for commit
        host.wr(ADDR_INDEX, 8'h01);
        host.wr(ADDR_CLOCK, 8'h00);
        settle;
        chk(dcs, 4'hF);
        host.commit;
        settle;
        chk(dcs, 4'hE);
        // fixed levels on A while B keeps conversion data
        for (int i = 1; i < 4; i++)
        begin
            host.wr(ADDR_TEST, 8'(i));
            host.commit;
            settle;
            chk(data_out, {sample[47:12], lvl[i-1]});
        end
        host.wr(ADDR_OUTFMT, 8'h04);
        host.commit;
        settle;
        chk(data_out[11:0], 12'hFFF);
        host.wr(ADDR_TEST, 8'h00);
        host.wr(ADDR_OUTFMT, 8'h41);
        host.commit;
        settle;
        chk(data_out, sample ^ 48'h800);
        chk(low_swing, 4'h1);
        host.wr(ADDR_MODES, 8'h05);
        rchk(ADDR_MODES, 8'h05);
        host.commit;
        settle;
        chk(run_mode, 12'h005);
        // clock lanes only, data channels untouched
        host.wr(ADDR_INDEX, 8'h30);
        host.wr(ADDR_OUTFMT, 8'h44);
        host.commit;
        settle;
        chk({lane_ls, lane_inv, low_swing}, 8'hF1);
        rchk(ADDR_OUTFMT, 8'h41);
        // every remaining code with both generator holds on B
        host.wr(ADDR_INDEX, 8'h02);
        for (int c = 4; c < 13; c++)
        begin
            host.wr(ADDR_TEST, 8'h30 | 8'(c));
            rchk(ADDR_TEST, 8'h30 | 8'(c));
        end
        // generators seeded all ones, first words after release follow the shift
        pchk(8'h35, 12'hFFF, 12'hFFF);
        pchk(8'h06, 12'hFC0, 12'hF80);
        pchk(8'h25, 12'hFFF, 12'hFFF);
        pchk(8'h05, 12'hFF8, 12'hFF0);
        pchk(8'h04, PAT_CHECK_A, PAT_CHECK_B);
        pchk(8'h07, PAT_POSFS, PAT_NEGFS);
        pchk(8'h08, 12'h123, 12'h234);
        pchk(8'h09, PAT_CHECK_A, PAT_CHECK_A);
        pchk(8'h0A, PAT_SYNC, PAT_SYNC);
        pchk(8'h0B, PAT_ONEHIGH, PAT_ONEHIGH);
        pchk(8'h0C, PAT_MIXED_A, PAT_MIXED_B);
        // mixed pattern follows twos complement format on channel B
        host.wr(ADDR_OUTFMT, 8'h01);
        pchk(8'h0C, PAT_MIXED_A ^ SIGN_FLIP, PAT_MIXED_B ^ SIGN_FLIP);
        final_report;
    end
endmodule

bind adc_channel_config_regs adc_channel_config_regs_asserts #(.CHANNELS(CHANNELS)) u_chk (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_write_in(reg_write_in), .rd_addr_in(rd_addr_in),
    .sample_in(sample_in), .user_pattern_in(user_pattern_in), .rd_data_out(rd_data_out), .data_out(data_out),
    .dcs_enable_out(dcs_enable_out), .low_swing_out(low_swing_out), .run_mode_out(run_mode_out),
    .clock_lane_low_swing_out(clock_lane_low_swing_out), .clock_lane_invert_out(clock_lane_invert_out));
